/* rtl/usrt_pkg.sv */
// package for the serial transmitter flags and receiver front path
// assumes a single 20 MHz clock domain; baud tick supplied from outside
package usrt_pkg;
   // char size codes
   localparam logic [2:0] CSZ_NINE = 3'h7;
   localparam logic [2:0] CSZ_FIVE = 3'h0;
   // receive fifo depth (two characters)
   localparam int RX_DEPTH = 2;
   localparam logic [1:0] RX_DEPTH_W = 2'h2;
   // bit counter widths
   localparam logic [3:0] BITCNT_ZERO = 4'h0;
   localparam logic [3:0] DATA_BASE = 4'h5;
   // line idle level
   localparam logic LINE_IDLE = 1'b1;
   // reset value of the tx buffer word
   localparam logic [8:0] WORD_RST = 9'h000;
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_START = 3'b001,
      TX_DATA = 3'b010,
      TX_PAR = 3'b011,
      TX_STOP = 3'b100
   } usrt_txst_e;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_DATA = 2'b01,
      RX_PAR = 2'b10,
      RX_STOP = 2'b11
   } usrt_rxst_e;
endpackage

/* rtl/usrt_core.sv */
// serial transmitter with flags and parity, plus receiver shift path and fifo
// assumes bitTick pulses once per bit time, inputs synchronous to clk
// Operation
// - buffer-empty flag high while tx buffer empty, low while word waits
// - buffer-empty interrupt requested while flag high and its enable set
// - writing the data register clears the buffer-empty flag
// - tx-complete flag sets when frame shifted out and buffer empty
// - tx-complete clears on interrupt service or a write of one
// - tx-complete interrupt raised when the flag becomes set, if enabled
// - upper parity bit set inserts parity after data, before stop
// - tx disable waits until shifter and buffer empty, then releases pin
// - rx enable takes over the receive pin as serial input
// - synchronous mode samples receive data on external transfer clock
// - frame begins on valid start bit, shifted until first stop bit
// - first stop bit moves frame from shifter into receive buffer
// - short frames read zeros in unused upper data bits
// - ninth bit and error flags stored per frame, advance on data read
// - rx-complete high while unread data; rx disable flushes buffer
// - overrun when buffer full, shifter holds char, new start bit arrives
`timescale 1ns/1ns
module usrt_core
   import usrt_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic bitTick,
   input wire logic syncMode,
   input wire logic ext_transfer_clock,
   input wire logic [2:0] char_size_code,
   input wire logic [1:0] parityMode,
   input wire logic tx_enable_bit,
   input wire logic rx_enable_bit,
   input wire logic tx_buffer_empty_irq_en,
   input wire logic tx_complete_irq_en,
   input wire logic tx_ninth_bit,
   input wire logic dataWrite,
   input wire logic [7:0] dataWriteValue,
   input wire logic txCompleteWriteOne,
   input wire logic txCompleteIrqAck,
   input wire logic dataRead,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic serialOutOe_n,
   output logic rxPinTaken,
   output logic tx_buffer_empty_flag,
   output logic tx_complete_flag,
   output logic txBufferEmptyIrq,
   output logic txCompleteIrq,
   output logic rx_complete_flag,
   output logic [7:0] rxData,
   output logic rx_ninth_bit,
   output logic frame_err_flag,
   output logic parity_err_flag,
   output logic overrun_flag
);
   import usrt_pkg::*;

   // ****************************************
   // frame geometry
   // ****************************************
   logic [3:0] nData;
   logic [8:0] dataMask;
   logic parity_mode_hi;
   // code 7 means nine bits, 0..3 mean five to eight
   assign nData = (char_size_code == CSZ_NINE) ? 4'h9 : (DATA_BASE + {2'b00, char_size_code[1:0]});
   assign dataMask = 9'h1FF >> (4'h9 - nData);
   assign parity_mode_hi = parityMode[1];

   // ****************************************
   // transmitter
   // ****************************************
   usrt_txst_e txSt_ff, nxt_txSt;
   logic [8:0] txBuf_ff, nxt_txBuf;
   logic txBufFull_ff, nxt_txBufFull;
   logic [8:0] txSh_ff, nxt_txSh;
   logic [3:0] txCnt_ff, nxt_txCnt;
   logic txPar_ff, nxt_txPar;
   logic txCpl_ff, nxt_txCpl;
   logic txOn_ff, nxt_txOn;
   logic txOut_ff, nxt_txOut;
   logic txDone;

   // tx next state; load from buffer when idle or right after the stop bit
   always_comb begin
      nxt_txSt = txSt_ff;
      nxt_txBuf = txBuf_ff;
      nxt_txBufFull = txBufFull_ff;
      nxt_txSh = txSh_ff;
      nxt_txCnt = txCnt_ff;
      nxt_txPar = txPar_ff;
      nxt_txCpl = txCpl_ff;
      nxt_txOut = txOut_ff;
      txDone = 1'b0;
      // enable turns on at once, off only when nothing is left
      nxt_txOn = tx_enable_bit | (txOn_ff & (txBufFull_ff | (txSt_ff != TX_IDLE)));
      if (bitTick) begin
         unique case (txSt_ff)
            TX_IDLE: nxt_txOut = LINE_IDLE;
            TX_START: begin
               nxt_txOut = txSh_ff[0];
               nxt_txSh = txSh_ff >> 1;
               nxt_txCnt = 4'h1;
               nxt_txSt = TX_DATA;
            end
            TX_DATA: begin
               if (txCnt_ff == nData) begin
                  nxt_txOut = parity_mode_hi ? txPar_ff : LINE_IDLE;
                  nxt_txSt = parity_mode_hi ? TX_PAR : TX_STOP;
               end else begin
                  nxt_txOut = txSh_ff[0];
                  nxt_txSh = txSh_ff >> 1;
                  nxt_txCnt = txCnt_ff + 4'h1;
               end
            end
            TX_PAR: begin
               nxt_txOut = LINE_IDLE;
               nxt_txSt = TX_STOP;
            end
            TX_STOP: begin
               txDone = 1'b1;
               nxt_txSt = TX_IDLE;
            end
            default: nxt_txSt = TX_IDLE;
         endcase
      end
      // shifter takes the buffer word when idle or at the end of a frame
      if (txBufFull_ff && txOn_ff && ((txSt_ff == TX_IDLE) || txDone)) begin
         nxt_txSh = txBuf_ff & dataMask;
         nxt_txPar = (^(txBuf_ff & dataMask)) ^ parityMode[0];
         nxt_txSt = TX_START;
         nxt_txOut = 1'b0;
         nxt_txBufFull = 1'b0;
      end
      // a write fills the buffer and drops the empty flag
      if (dataWrite) begin
         nxt_txBuf = {tx_ninth_bit, dataWriteValue};
         nxt_txBufFull = 1'b1;
      end
      // complete flag: set wins over both clears
      if (txCompleteWriteOne || txCompleteIrqAck) begin
         nxt_txCpl = 1'b0;
      end
      if (txDone && !txBufFull_ff) begin
         nxt_txCpl = 1'b1;
      end
      if (!nxt_txOn) begin
         nxt_txOut = LINE_IDLE;
      end
   end

   // tx registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txSt_ff <= TX_IDLE;
         txBuf_ff <= WORD_RST;
         txBufFull_ff <= 1'b0;
         txSh_ff <= WORD_RST;
         txCnt_ff <= BITCNT_ZERO;
         txPar_ff <= 1'b0;
         txCpl_ff <= 1'b0;
         txOn_ff <= 1'b0;
         txOut_ff <= LINE_IDLE;
      end else begin
         txSt_ff <= nxt_txSt;
         txBuf_ff <= nxt_txBuf;
         txBufFull_ff <= nxt_txBufFull;
         txSh_ff <= nxt_txSh;
         txCnt_ff <= nxt_txCnt;
         txPar_ff <= nxt_txPar;
         txCpl_ff <= nxt_txCpl;
         txOn_ff <= nxt_txOn;
         txOut_ff <= nxt_txOut;
      end
   end

   // tx flags and requests
   assign tx_buffer_empty_flag = ~txBufFull_ff;
   assign txBufferEmptyIrq = tx_buffer_empty_flag & tx_buffer_empty_irq_en;
   assign tx_complete_flag = txCpl_ff;
   assign txCompleteIrq = txCpl_ff & tx_complete_irq_en;
   assign serial_out_pin = txOut_ff;
   assign serialOutOe_n = ~txOn_ff;

   // ****************************************
   // receiver
   // ****************************************
   usrt_rxst_e rxSt_ff, nxt_rxSt;
   logic [8:0] rxSh_ff, nxt_rxSh;
   logic [3:0] rxCnt_ff, nxt_rxCnt;
   logic rxParBit_ff, nxt_rxParBit;
   logic rxWait_ff, nxt_rxWait;
   logic [12:0] rxWaitWord_ff, nxt_rxWaitWord;
   logic rxOvr_ff, nxt_rxOvr;
   logic xckPrev_ff, nxt_xckPrev;
   logic [12:0] fifo_ff [RX_DEPTH];
   logic [12:0] nxt_fifo [RX_DEPTH];
   logic [1:0] fifoCnt_ff, nxt_fifoCnt;
   logic sampleEn;
   logic rxIn;
   logic [8:0] rxWord;
   logic [12:0] pushWord;

   // pin is owned by the receiver only while enabled
   assign rxPinTaken = rx_enable_bit;
   assign rxIn = rx_enable_bit ? serial_in_pin : LINE_IDLE;
   // synchronous mode samples on the rising edge of the transfer clock
   assign sampleEn = syncMode ? (ext_transfer_clock & ~xckPrev_ff) : bitTick;
   // right-align the shifted data; unused high bits are zero
   assign rxWord = (rxSh_ff >> (4'h9 - nData)) & dataMask;

   // rx next state
   always_comb begin
      nxt_rxSt = rxSt_ff;
      nxt_rxSh = rxSh_ff;
      nxt_rxCnt = rxCnt_ff;
      nxt_rxParBit = rxParBit_ff;
      nxt_rxWait = rxWait_ff;
      nxt_rxWaitWord = rxWaitWord_ff;
      nxt_rxOvr = rxOvr_ff;
      nxt_xckPrev = ext_transfer_clock;
      nxt_fifoCnt = fifoCnt_ff;
      for (int i = 0; i < RX_DEPTH; i++) begin
         nxt_fifo[i] = fifo_ff[i];
      end
      pushWord = 13'h0000;
      // read pops the head; status and ninth bit move with it
      if (dataRead && fifoCnt_ff != 2'h0) begin
         nxt_fifo[0] = fifo_ff[1];
         nxt_fifoCnt = fifoCnt_ff - 2'h1;
      end
      // move the waiting word into the buffer when a slot is free
      if (rxWait_ff && nxt_fifoCnt != RX_DEPTH_W) begin
         pushWord = rxWaitWord_ff;
         nxt_fifo[nxt_fifoCnt[0]] = pushWord;
         nxt_fifoCnt = nxt_fifoCnt + 2'h1;
         nxt_rxWait = 1'b0;
      end
      // push is settled first so a stop bit in the same cycle can reuse the waiting slot
      if (sampleEn) begin
         unique case (rxSt_ff)
            RX_IDLE: begin
               if (rxIn == 1'b0) begin
                  nxt_rxSt = RX_DATA;
                  nxt_rxCnt = BITCNT_ZERO;
                  // full buffer plus a waiting word: this frame is lost
                  if (fifoCnt_ff == RX_DEPTH_W && rxWait_ff) begin
                     nxt_rxOvr = 1'b1;
                  end
               end
            end
            RX_DATA: begin
               nxt_rxSh = {rxIn, rxSh_ff[8:1]};
               nxt_rxCnt = rxCnt_ff + 4'h1;
               if (rxCnt_ff + 4'h1 == nData) begin
                  nxt_rxSt = parity_mode_hi ? RX_PAR : RX_STOP;
               end
            end
            RX_PAR: begin
               nxt_rxParBit = rxIn;
               nxt_rxSt = RX_STOP;
            end
            RX_STOP: begin
               // only the first stop bit is looked at
               nxt_rxSt = RX_IDLE;
               if (!nxt_rxWait) begin
                  nxt_rxWait = 1'b1;
                  // word layout: spare, overrun, parity err, frame err, 9 data bits
                  nxt_rxWaitWord = {1'b0, rxOvr_ff,
                     parity_mode_hi & ((^rxWord) ^ parityMode[0] ^ rxParBit_ff),
                     ~rxIn, rxWord};
                  nxt_rxOvr = 1'b0;
               end
            end
         endcase
      end
      // disable is immediate: ongoing frame and buffer are dropped
      if (!rx_enable_bit) begin
         nxt_rxSt = RX_IDLE;
         nxt_fifoCnt = 2'h0;
         nxt_rxWait = 1'b0;
         nxt_rxOvr = 1'b0;
      end
   end

   // rx registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxSt_ff <= RX_IDLE;
         rxSh_ff <= WORD_RST;
         rxCnt_ff <= BITCNT_ZERO;
         rxParBit_ff <= 1'b0;
         rxWait_ff <= 1'b0;
         rxWaitWord_ff <= 13'h0000;
         rxOvr_ff <= 1'b0;
         xckPrev_ff <= 1'b0;
         fifoCnt_ff <= 2'h0;
      end else begin
         rxSt_ff <= nxt_rxSt;
         rxSh_ff <= nxt_rxSh;
         rxCnt_ff <= nxt_rxCnt;
         rxParBit_ff <= nxt_rxParBit;
         rxWait_ff <= nxt_rxWait;
         rxWaitWord_ff <= nxt_rxWaitWord;
         rxOvr_ff <= nxt_rxOvr;
         xckPrev_ff <= nxt_xckPrev;
         fifoCnt_ff <= nxt_fifoCnt;
      end
   end

   // fifo storage, one register per entry
   for (genvar g = 0; g < RX_DEPTH; g++) begin : gFifo
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            fifo_ff[g] <= 13'h0000;
         end else begin
            fifo_ff[g] <= nxt_fifo[g];
         end
      end
   end

   // head of the fifo drives the read side
   assign rx_complete_flag = (fifoCnt_ff != 2'h0);
   assign rxData = fifo_ff[0][7:0];
   assign rx_ninth_bit = fifo_ff[0][8];
   assign frame_err_flag = fifo_ff[0][9];
   assign parity_err_flag = fifo_ff[0][10];
   assign overrun_flag = fifo_ff[0][11];
endmodule

/* tb/usrt_assertions.sv */
// checker on the core ports
// assumes it is bound onto usrt_core
`timescale 1ns/1ns
module usrt_assertions
   import usrt_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic dataWrite,
   input wire logic txCompleteWriteOne,
   input wire logic txCompleteIrqAck,
   input wire logic tx_enable_bit,
   input wire logic rx_enable_bit,
   input wire logic tx_buffer_empty_irq_en,
   input wire logic tx_complete_irq_en,
   input wire logic [2:0] char_size_code,
   input wire logic serial_out_pin,
   input wire logic serialOutOe_n,
   input wire logic rxPinTaken,
   input wire logic tx_buffer_empty_flag,
   input wire logic tx_complete_flag,
   input wire logic txBufferEmptyIrq,
   input wire logic txCompleteIrq,
   input wire logic rx_complete_flag,
   input wire logic [7:0] rxData
);
   // ********
   // rules
   // ********
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   chk_write_clears_empty: assert property (dataWrite |=> !tx_buffer_empty_flag)
      else $error("empty flag held after write");
   chk_empty_irq_level: assert property (txBufferEmptyIrq == (tx_buffer_empty_flag && tx_buffer_empty_irq_en))
      else $error("empty irq wrong");
   chk_tc_irq_level: assert property (txCompleteIrq == (tx_complete_flag && tx_complete_irq_en))
      else $error("complete irq wrong");
   // a frame ends on a high stop bit with nothing queued
   chk_tc_needs_empty: assert property ($rose(tx_complete_flag) |-> tx_buffer_empty_flag && serial_out_pin)
      else $error("complete set too early");
   chk_tc_clear_one: assert property (tx_complete_flag && (txCompleteWriteOne || txCompleteIrqAck) |=> !tx_complete_flag)
      else $error("complete not cleared");
   chk_pin_release: assert property ($rose(serialOutOe_n) |-> !$past(tx_enable_bit) && tx_buffer_empty_flag)
      else $error("pin released while busy");
   chk_rx_takes_pin: assert property (rxPinTaken == rx_enable_bit)
      else $error("rx pin takeover wrong");
   chk_rx_flush: assert property (!rx_enable_bit [*2] |-> !rx_complete_flag)
      else $error("rx buffer not flushed");
   chk_short_upper_zero: assert property (rx_complete_flag && char_size_code == CSZ_FIVE |-> rxData[7:5] == 3'h0)
      else $error("short frame upper bits set");
endmodule

/* tb/usrt_peer.sv */
// remote serial transmitter on the receive line
// assumes bitTick is a one-clock pulse; bits change one clock after it
`timescale 1ns/1ns
module usrt_peer (
   output logic lineOut,
   output logic xckOut,
   input wire logic clk,
   input wire logic bitTick
);
   // idle line is high between frames
   initial lineOut = 1'b1;
   // transfer clock stands low outside synchronous frames
   initial xckOut = 1'b0;
   // synchronous bit: six clocks long, so the internal bit tick cannot stand in for it
   task automatic put_sync(input logic b);
      @(posedge clk);
      lineOut <= b;
      xckOut <= 1'b0;
      repeat (3) @(posedge clk);
      xckOut <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   task automatic send_sync(input logic [8:0] w, input int n);
      put_sync(1'b0);
      for (int i = 0; i < n; i++) begin
         put_sync(w[i]);
      end
      put_sync(1'b1);
      @(posedge clk);
      xckOut <= 1'b0;
   endtask
   // change one clock after the tick so the sampling tick never sees an edge
   task automatic put_bit(input logic b);
      @(posedge clk iff bitTick);
      @(posedge clk);
      lineOut <= b;
   endtask
   // errors only when the scenario asks for them
   task automatic send(input logic [8:0] w, input int n, input logic [1:0] pm, input logic bp, input logic bs);
      logic par;
      par = pm[0] ^ bp;
      put_bit(1'b0);
      for (int i = 0; i < n; i++) begin
         put_bit(w[i]);
         par = par ^ w[i];
      end
      if (pm[1]) put_bit(par);
      put_bit(~bs);
      put_bit(1'b1);
   endtask
endmodule

/* tb/usrt_tb_top.sv */
// bench for the usart core
// assumes usrt_peer on the receive line, bitTick every 4 clocks
`timescale 1ns/1ns
module usart_tx_flags_rx_path_tb_top;
   import usrt_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, bitTick = 1'b0, syncMode = 1'b0;
   logic tx_enable_bit = 1'b0, rx_enable_bit = 1'b0, tx_buffer_empty_irq_en = 1'b1, tx_complete_irq_en = 1'b1;
   logic tx_ninth_bit = 1'b0, dataWrite = 1'b0, txCompleteWriteOne = 1'b0, txCompleteIrqAck = 1'b0, dataRead = 1'b0;
   logic [2:0] char_size_code = 3'h3;
   logic [1:0] parityMode = 2'h0, tickCnt = 2'h0;
   logic [7:0] dataWriteValue = 8'h00, rxData;
   logic ext_transfer_clock, serial_in_pin, serial_out_pin, serialOutOe_n, rxPinTaken, tx_buffer_empty_flag;
   logic tx_complete_flag;
   logic txBufferEmptyIrq, txCompleteIrq, rx_complete_flag, rx_ninth_bit, frame_err_flag, parity_err_flag, overrun_flag;
   int n_mismatch = 0, n_compared = 0, cycles = 0;
   usrt_core usrt_core_i (.*);
   usrt_peer usrt_peer_i (.lineOut(serial_in_pin), .xckOut(ext_transfer_clock), .clk(clk), .bitTick(bitTick));
   // ************
   // clock, tick
   // ************
   always #25 clk = ~clk;
   // bit rate kept at clk/4 so a frame costs few cycles
   always @(posedge clk) begin
      tickCnt <= tickCnt + 2'h1;
      bitTick <= (tickCnt == 2'h3);
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   // ************
   // helpers
   // ************
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic clk_n(input int n);
      repeat (n) @(posedge clk);
   endtask
   // bounded wait; a miss shows up in the next compare
   task automatic wait_for(ref logic sig, input logic lvl);
      for (int i = 0; i < 400 && sig !== lvl; i++) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic write(input logic [8:0] w);
      @(posedge clk);
      dataWriteValue <= w[7:0];
      tx_ninth_bit <= w[8];
      dataWrite <= 1'b1;
      @(posedge clk);
      dataWrite <= 1'b0;
   endtask
   task automatic tx_bit();
      @(posedge clk iff bitTick);
      #1;
   endtask
   task automatic tx_frame(input logic [8:0] w, input int n, input logic [1:0] pm, input logic expTc);
      logic par;
      par = pm[0];
      wait_for(serial_out_pin, 1'b0);
      check("start", serial_out_pin, 1'b0);
      for (int i = 0; i < n; i++) begin
         tx_bit();
         check("data", serial_out_pin, w[i]);
         par = par ^ w[i];
      end
      if (pm[1]) begin
         tx_bit();
         check("parity", serial_out_pin, par);
      end
      tx_bit();
      check("stop", serial_out_pin, 1'b1);
      check("driven", serialOutOe_n, 1'b0);
      tx_bit();
      clk_n(1);
      #1;
      check("tx complete", tx_complete_flag, expTc);
      check("tc irq", txCompleteIrq, expTc);
   endtask
   task automatic rx_read(input logic [8:0] exp, input logic pe, input logic fe, input logic nine, input logic ov);
      wait_for(rx_complete_flag, 1'b1);
      check("rx data", rxData, exp[7:0]);
      if (nine) check("ninth", rx_ninth_bit, exp[8]);
      check("parity err", parity_err_flag, pe);
      check("frame err", frame_err_flag, fe);
      check("overrun", overrun_flag, ov);
      @(posedge clk);
      dataRead <= 1'b1;
      @(posedge clk);
      dataRead <= 1'b0;
      // let the pop settle before anyone looks at the head again
      #1;
   endtask
   // ************
   // scenarios
   // ************
   task automatic t_tx_formats();
      logic [2:0] sz [4] = '{3'h0, 3'h3, 3'h3, 3'h7};
      logic [1:0] pm [4] = '{2'h2, 2'h0, 2'h3, 2'h3};
      logic [8:0] w [4] = '{9'h0F6, 9'h0A5, 9'h03C, 9'h1C3};
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         char_size_code <= sz[k];
         parityMode <= pm[k];
         write(w[k]);
         #1;
         check("empty low", tx_buffer_empty_flag, 1'b0);
         check("empty irq low", txBufferEmptyIrq, 1'b0);
         tx_frame(w[k], (sz[k] == CSZ_NINE) ? 9 : sz[k] + 5, pm[k], 1'b1);
         check("empty high", tx_buffer_empty_flag, 1'b1);
         check("empty irq", txBufferEmptyIrq, 1'b1);
         @(posedge clk);
         txCompleteWriteOne <= 1'b1;
         @(posedge clk);
         txCompleteWriteOne <= 1'b0;
         #1;
         check("tc cleared", tx_complete_flag, 1'b0);
      end
      $display("tx formats done");
   endtask
   task automatic t_tx_b2b();
      @(posedge clk);
      char_size_code <= 3'h3;
      parityMode <= 2'h0;
      write(9'h05A);
      fork
         tx_frame(9'h05A, 8, 2'h0, 1'b0);
         begin
            clk_n(3);
            write(9'h0C3);
            tx_enable_bit <= 1'b0;
            #1;
            check("empty waits", tx_buffer_empty_flag, 1'b0);
         end
      join
      tx_frame(9'h0C3, 8, 2'h0, 1'b1);
      clk_n(2);
      #1;
      check("released", serialOutOe_n, 1'b1);
      @(posedge clk);
      txCompleteIrqAck <= 1'b1;
      @(posedge clk);
      txCompleteIrqAck <= 1'b0;
      tx_enable_bit <= 1'b1;
      #1;
      check("tc acked", tx_complete_flag, 1'b0);
      $display("tx back to back done");
   endtask
   task automatic t_rx_formats();
      logic [2:0] sz [5] = '{3'h0, 3'h3, 3'h7, 3'h3, 3'h3};
      logic [1:0] pm [5] = '{2'h2, 2'h0, 2'h3, 2'h2, 2'h0};
      logic [8:0] w [5] = '{9'h1F5, 9'h0A5, 9'h1C3, 9'h05A, 9'h0F0};
      logic [4:0] bp = 5'h08, bs = 5'h10;
      int n;
      for (int k = 0; k < 5; k++) begin
         @(posedge clk);
         char_size_code <= sz[k];
         parityMode <= pm[k];
         n = (sz[k] == CSZ_NINE) ? 9 : sz[k] + 5;
         usrt_peer_i.send(w[k], n, pm[k], bp[k], bs[k]);
         rx_read(w[k] & ((9'h001 << n) - 9'h001), bp[k], bs[k], sz[k] == CSZ_NINE, 1'b0);
      end
      $display("rx formats done");
   endtask
   task automatic t_rx_sync();
      @(posedge clk);
      syncMode <= 1'b1;
      char_size_code <= 3'h3;
      parityMode <= 2'h0;
      usrt_peer_i.send_sync(9'h096, 8);
      rx_read(9'h096, 1'b0, 1'b0, 1'b0, 1'b0);
      @(posedge clk);
      syncMode <= 1'b0;
      $display("rx sync done");
   endtask
   task automatic t_rx_overrun();
      @(posedge clk);
      char_size_code <= 3'h3;
      parityMode <= 2'h0;
      // two in the buffer, one waiting: the fourth frame is lost
      for (int k = 1; k < 5; k++) usrt_peer_i.send(9'(k * 17), 8, 2'h0, 1'b0, 1'b0);
      check("oldest first", rxData, 8'h11);
      for (int k = 1; k < 4; k++) rx_read(9'(k * 17), 1'b0, 1'b0, 1'b0, 1'b0);
      // the loss is reported with the next frame that gets stored
      usrt_peer_i.send(9'h05A, 8, 2'h0, 1'b0, 1'b0);
      rx_read(9'h05A, 1'b0, 1'b0, 1'b0, 1'b1);
      usrt_peer_i.send(9'h0A5, 8, 2'h0, 1'b0, 1'b0);
      wait_for(rx_complete_flag, 1'b1);
      @(posedge clk);
      rx_enable_bit <= 1'b0;
      clk_n(2);
      #1;
      check("flushed", rx_complete_flag, 1'b0);
      check("pin free", rxPinTaken, 1'b0);
      $display("rx overrun and flush done");
   endtask
   initial begin
      clk_n(5);
      rst_n <= 1'b1;
      tx_enable_bit <= 1'b1;
      rx_enable_bit <= 1'b1;
      clk_n(2);
      t_tx_formats();
      t_tx_b2b();
      t_rx_formats();
      t_rx_sync();
      t_rx_overrun();
      give_verdict();
   end
endmodule
bind usrt_core usrt_assertions usrt_assertions_i (.*);
